// ===== shared/ewl_pkg.sv
// Shared constants for the two-wire serial memory slave link.
package ewl_pkg;

    // ************************************************************
    // Byte framing
    // ************************************************************
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned BIT_CNT_W     = 4;
    localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
    localparam logic [3:0]  ACK_SLOT_BIT  = 4'h8;
    localparam logic [3:0]  BIT_CNT_RST   = 4'h0;

    // ************************************************************
    // Input filtering, in link clock cycles
    // ************************************************************
    localparam int unsigned FILT_LEN      = 2;
    localparam int unsigned FILT_CNT_W    = 2;
    localparam logic [1:0]  FILT_CNT_RST  = 2'h0;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic        SDA_OE_RST    = 1'b0;
    localparam logic        LINE_IDLE_RST = 1'b1;
    localparam logic        STANDBY_RST   = 1'b0;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    localparam logic [3:0]  EVT_RST       = 4'h0;
    localparam logic [10:0] CTRL_RST      = 11'h000;

    // ************************************************************
    // Event toggle positions crossing from the link domain
    // ************************************************************
    localparam int unsigned EV_START      = 0;
    localparam int unsigned EV_STOP       = 1;
    localparam int unsigned EV_RX         = 2;
    localparam int unsigned EV_NACK       = 3;
    localparam int unsigned EV_W          = 4;

    // ************************************************************
    // Link states
    // ************************************************************
    typedef enum logic [1:0] {
        LS_IDLE,
        LS_BITS,
        LS_ACK,
        LS_WAIT
    } ewl_link_state_t;

endpackage

// ===== rtl/ewl_filt.sv
// Two-stage synchroniser followed by a stability filter for one bus line.
module ewl_filt
    import ewl_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);

    logic                  s1_r;
    logic                  s2_r;
    logic [FILT_CNT_W-1:0] cnt_r;

    // ************************************************************
    // Synchroniser
    // ************************************************************
    always_ff @(posedge clk) begin
        s1_r <= din;
        s2_r <= s1_r;
    end

    // ************************************************************
    // Filter: the output follows only after FILT_LEN equal samples.
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= FILT_CNT_RST;
            dout  <= LINE_IDLE_RST;
        end else if (s2_r == dout) begin
            cnt_r <= FILT_CNT_RST;
        end else if (cnt_r == FILT_CNT_W'(FILT_LEN - 1)) begin
            cnt_r <= FILT_CNT_RST;
            dout  <= s2_r; // RL20
        end else begin
            cnt_r <= cnt_r + FILT_CNT_W'(1);
        end
    end

endmodule // ewl_filt

// ===== rtl/ewl_link.sv
// Bit-level slave side of a two-wire serial memory link.
// Contract
// RL1: Ignore bus until power-on release, then enter standby.
// RL2: Master waits at least 100 microseconds after stable supply before commanding.
// RL3: Sample data on clock rise, change driven data only after clock fall.
// RL4: Bytes move most significant bit first, one bit per clock period.
// RL5: Each byte takes nine clocks: eight data bits and one acknowledge bit.
// RL6: Master supplies every clock of a byte without pauses.
// RL7: Data changes only while clock is low, except start and stop.
// RL8: Data falling while clock high is a start and wakes from standby.
// RL9: Every command opens with start; device stays silent until one is seen.
// RL10: Data rising while clock high is a stop; end transfer, go standby.
// RL11: A repeated start may replace a stop and must be accepted.
// RL12: Bytes per transfer are unlimited by the device.
// RL13: Bus is idle only while clock and data are both high.
// RL14: Transmitter releases after eighth fall; receiver holds low through ninth high.
// RL15: Receiver releases data at end of the ninth clock.
// RL16: High bit from master in ninth clock ends a read; device releases.
// RL17: Standby after reset release, after stop without write, after write completion.
// RL18: Recovery: clocks until data released, at most nine, then start.
// RL19: Bus inputs are ignored during an internal write cycle.
// RL20: Clock and data inputs are synchronised and deglitched.
module ewl_link
    import ewl_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic              link_clk,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    input  wire logic              power_on_release,
    input  wire logic              write_busy,
    input  wire logic              write_pending,
    input  wire logic              ack_en,
    input  wire logic              tx_mode,
    input  wire logic [BYTE_W-1:0] tx_data,
    output logic [BYTE_W-1:0]      rx_data,
    output logic                   rx_valid,
    output logic                   start_evt,
    output logic                   stop_evt,
    output logic                   nack_evt,
    output logic                   standby,
    output logic                   bus_idle
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                  por_s1_r;
    logic                  por_s2_r;
    logic                  busy_d_r;
    logic                  link_en;
    logic [EV_W-1:0]       ev_s1_r;
    logic [EV_W-1:0]       ev_s2_r;
    logic [EV_W-1:0]       ev_s3_r;
    logic [EV_W-1:0]       ev_pulse;
    logic                  awake_r;

    logic                  lrst_s1_r;
    logic                  lrst_r;
    logic [10:0]           ctl_s1_r;
    logic [10:0]           ctl_s2_r;
    logic                  l_en;
    logic                  l_ack_en;
    logic                  l_tx_mode;
    logic [BYTE_W-1:0]     l_tx_data;
    logic                  scl_f;
    logic                  sda_f;
    logic                  scl_p_r;
    logic                  sda_p_r;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_det;
    logic                  stop_det;
    ewl_link_state_t       state_r;
    logic [BIT_CNT_W-1:0]  bit_cnt_r;
    logic                  sending_r;
    logic [BYTE_W-1:0]     shift_r;
    logic [BYTE_W-1:0]     rx_hold_r;
    logic [EV_W-1:0]       ev_tg_r;
    logic                  sda_o_r;
    logic                  sda_oe_r;

    // ************************************************************
    // System domain: power-on release and enable
    // ************************************************************
    always_ff @(posedge clock) begin
        por_s1_r <= power_on_release;
        por_s2_r <= por_s1_r;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            busy_d_r <= 1'b0;
        end else begin
            busy_d_r <= write_busy;
        end
    end

    assign link_en = por_s2_r & ~write_busy; // RL1 RL19

    // ************************************************************
    // System domain: events arriving from the link
    // ************************************************************
    always_ff @(posedge clock) begin
        ev_s1_r <= ev_tg_r;
        ev_s2_r <= ev_s1_r;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ev_s3_r <= EVT_RST;
        end else begin
            ev_s3_r <= ev_s2_r;
        end
    end

    // Each event toggles once in the link domain and becomes one pulse here.
    assign ev_pulse = ev_s2_r ^ ev_s3_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            start_evt <= 1'b0;
            stop_evt  <= 1'b0;
            rx_valid  <= 1'b0;
            nack_evt  <= 1'b0;
            rx_data   <= BYTE_RST;
        end else begin
            start_evt <= ev_pulse[EV_START];
            stop_evt  <= ev_pulse[EV_STOP];
            rx_valid  <= ev_pulse[EV_RX];
            nack_evt  <= ev_pulse[EV_NACK];
            if (ev_pulse[EV_RX]) begin
                rx_data <= rx_hold_r;
            end
        end
    end

    // ************************************************************
    // System domain: standby tracking
    // ************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            awake_r <= 1'b0;
            standby <= STANDBY_RST;
        end else begin
            if (ev_pulse[EV_START] && link_en) begin
                awake_r <= 1'b1; // RL8
            end else if (ev_pulse[EV_STOP] && !write_pending && !write_busy) begin
                awake_r <= 1'b0; // RL10 RL17
            end else if (busy_d_r && !write_busy) begin
                awake_r <= 1'b0; // RL17
            end
            standby <= por_s2_r & ~awake_r & ~write_busy; // RL1 RL17
        end
    end

    // ************************************************************
    // Link domain: reset and control levels
    // ************************************************************
    always_ff @(posedge link_clk) begin
        lrst_s1_r <= srst;
        lrst_r    <= lrst_s1_r;
    end

    // Control levels are quasi-static; tx_data must hold from the ack slot to its fall.
    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            ctl_s1_r <= CTRL_RST;
            ctl_s2_r <= CTRL_RST;
        end else begin
            ctl_s1_r <= {link_en, ack_en, tx_mode, tx_data};
            ctl_s2_r <= ctl_s1_r;
        end
    end

    assign l_en      = ctl_s2_r[10];
    assign l_ack_en  = ctl_s2_r[9];
    assign l_tx_mode = ctl_s2_r[8];
    assign l_tx_data = ctl_s2_r[7:0];

    // ************************************************************
    // Link domain: filtered lines and conditions
    // ************************************************************
    ewl_filt u_scl_filt (
        .clk  (link_clk),
        .rst  (lrst_r),
        .din  (scl_i),
        .dout (scl_f)
    ); // RL20

    ewl_filt u_sda_filt (
        .clk  (link_clk),
        .rst  (lrst_r),
        .din  (sda_i),
        .dout (sda_f)
    ); // RL20

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            scl_p_r  <= LINE_IDLE_RST;
            sda_p_r  <= LINE_IDLE_RST;
            bus_idle <= LINE_IDLE_RST;
        end else begin
            scl_p_r  <= scl_f;
            sda_p_r  <= sda_f;
            bus_idle <= scl_f & sda_f; // RL13
        end
    end

    assign scl_rise  = scl_f & ~scl_p_r;
    assign scl_fall  = ~scl_f & scl_p_r;
    assign start_det = scl_f & scl_p_r & sda_p_r & ~sda_f; // RL8
    assign stop_det  = scl_f & scl_p_r & ~sda_p_r & sda_f; // RL10

    // ************************************************************
    // Link domain: byte framing state machine
    // ************************************************************
    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            state_r   <= LS_IDLE;
            bit_cnt_r <= BIT_CNT_RST;
            sending_r <= 1'b0;
            shift_r   <= BYTE_RST;
            rx_hold_r <= BYTE_RST;
            ev_tg_r   <= EVT_RST;
            sda_o_r   <= 1'b0;
            sda_oe_r  <= SDA_OE_RST;
        end else if (!l_en) begin
            state_r  <= LS_IDLE; // RL1 RL19
            sda_oe_r <= 1'b0;
        end else if (start_det) begin
            // The clock fall that closes a start comes before the first data bit.
            state_r           <= LS_BITS; // RL9 RL11
            bit_cnt_r         <= BIT_CNT_RST - BIT_CNT_W'(1); // RL5
            sending_r         <= 1'b0;
            sda_oe_r          <= 1'b0;
            ev_tg_r[EV_START] <= ~ev_tg_r[EV_START];
        end else if (stop_det) begin
            state_r          <= LS_IDLE; // RL10
            sda_oe_r         <= 1'b0;
            ev_tg_r[EV_STOP] <= ~ev_tg_r[EV_STOP];
        end else begin
            unique case (state_r)
                LS_IDLE: begin
                    sda_oe_r <= 1'b0; // RL9
                end
                LS_BITS: begin
                    if (scl_rise && !sending_r) begin
                        shift_r <= {shift_r[BYTE_W-2:0], sda_f}; // RL3 RL4
                    end
                    if (scl_fall) begin
                        if (bit_cnt_r == LAST_DATA_BIT) begin
                            state_r   <= LS_ACK; // RL5
                            bit_cnt_r <= ACK_SLOT_BIT;
                            if (sending_r) begin
                                sda_oe_r <= 1'b0; // RL14
                            end else begin
                                sda_oe_r        <= l_ack_en; // RL14
                                rx_hold_r       <= shift_r;
                                ev_tg_r[EV_RX]  <= ~ev_tg_r[EV_RX];
                            end
                        end else begin
                            bit_cnt_r <= bit_cnt_r + BIT_CNT_W'(1);
                            if (sending_r) begin
                                sda_oe_r <= ~shift_r[BYTE_W-1]; // RL3 RL4 RL7
                                shift_r  <= {shift_r[BYTE_W-2:0], 1'b0};
                            end
                        end
                    end
                end
                LS_ACK: begin
                    if (scl_rise && sending_r && sda_f) begin
                        state_r          <= LS_WAIT; // RL16
                        sda_oe_r         <= 1'b0;
                        ev_tg_r[EV_NACK] <= ~ev_tg_r[EV_NACK];
                    end else if (scl_fall) begin
                        state_r   <= LS_BITS; // RL12
                        bit_cnt_r <= BIT_CNT_RST;
                        sending_r <= l_tx_mode;
                        if (l_tx_mode) begin
                            sda_oe_r <= ~l_tx_data[BYTE_W-1]; // RL3 RL4 RL15
                            shift_r  <= {l_tx_data[BYTE_W-2:0], 1'b0};
                        end else begin
                            sda_oe_r <= 1'b0; // RL15
                        end
                    end
                end
                LS_WAIT: begin
                    sda_oe_r <= 1'b0; // RL16 RL18
                end
            endcase
        end
    end

    // The data pin is open drain: only its enable ever changes.
    assign sda_o  = sda_o_r;
    assign sda_oe = sda_oe_r;

endmodule // ewl_link

// ===== bench/ewl_link_props.sv
// Concurrent checks on the slave link ports.
module ewl_link_props (
    input wire logic clock,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe,
    input wire logic power_on_release,
    input wire logic write_busy,
    input wire logic write_pending,
    input wire logic rx_valid,
    input wire logic start_evt,
    input wire logic stop_evt,
    input wire logic nack_evt,
    input wire logic standby,
    input wire logic bus_idle
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Properties
    // ********
    sequence s_por_low;
        !power_on_release [*4];
    endsequence
    sequence s_scl_low;
        (power_on_release && !write_busy && !scl_i) [*8];
    endsequence
    AST_POR_STANDBY: assert property (@(posedge clock) disable iff (srst)
        s_por_low |-> !standby) else $error("standby while supply low");
    AST_POR_SILENT: assert property (@(posedge link_clk) disable iff (srst)
        s_por_low |-> !sda_oe) else $error("data driven while supply low");
    AST_BUSY_SILENT: assert property (@(posedge link_clk) disable iff (srst)
        write_busy [*4] |-> !sda_oe) else $error("data driven during write");
    AST_OE_RISE: assert property (@(posedge link_clk) disable iff (srst)
        $rose(sda_oe) |-> !scl_i) else $error("data driven while clock high");
    AST_IDLE_HIGH: assert property (@(posedge link_clk) disable iff (srst)
        (power_on_release && !write_busy && scl_i && sda_i) [*8] |-> bus_idle)
        else $error("idle flag missing");
    AST_IDLE_LOW: assert property (@(posedge link_clk) disable iff (srst)
        s_scl_low |-> !bus_idle) else $error("idle flag with clock low");
    AST_START_WAKE: assert property (@(posedge clock) disable iff (srst)
        start_evt |-> ##[0:3] !standby) else $error("start did not wake");
    AST_RX_PULSE: assert property (@(posedge clock) disable iff (srst)
        rx_valid |=> !rx_valid) else $error("receive pulse too long");
    AST_NACK_REL: assert property (@(posedge clock) disable iff (srst)
        nack_evt |-> !sda_oe) else $error("data held after end of read");
    AST_STOP_SB: assert property (@(posedge clock) disable iff (srst)
        (stop_evt && !write_pending && !write_busy) |-> ##[0:3] standby)
        else $error("no standby after stop");
endmodule // ewl_link_props

bind ewl_link ewl_link_props p_u (
    .clock, .srst, .link_clk, .scl_i, .sda_i, .sda_oe, .power_on_release,
    .write_busy, .write_pending, .rx_valid, .start_evt, .stop_evt,
    .nack_evt, .standby, .bus_idle
);

// ===== bench/ewl_master.sv
// Bus master model that makes the serial clock and pulls the data line.
module ewl_master (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Bit and frame tasks
    // ********
    localparam int Q = 1280;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic bit_x(input logic b, output logic seen);
        #Q sda_pull = !b;
        #Q scl = 1'b1;
        #Q seen = sda;
        #Q scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic a,
                        output logic [7:0] got, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], got[i]);
        bit_x(a, ack);
    endtask
    task automatic start_c();
        #Q sda_pull = 1'b0;
        #Q scl = 1'b1;
        #(2*Q) sda_pull = 1'b1;
        #(2*Q) scl = 1'b0;
    endtask
    task automatic stop_c();
        #Q sda_pull = 1'b1;
        #Q scl = 1'b1;
        #(2*Q) sda_pull = 1'b0;
        #(2*Q);
    endtask
    task automatic spike();
        sda_pull = 1'b1;
        #40 sda_pull = 1'b0;
    endtask
endmodule // ewl_master

// ===== bench/eeprom_two_wire_slave_link_bench.sv
// Self-checking bench for the two-wire slave link.
module eeprom_two_wire_slave_link_bench import ewl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Signals and instances
    // ********
    logic              clock = 1'b0;
    logic              link_clk = 1'b0;
    logic              srst = 1'b1;
    logic              power_on_release = 1'b0;
    logic              write_busy = 1'b0;
    logic              write_pending = 1'b0;
    logic              ack_en = 1'b1;
    logic              tx_mode = 1'b0;
    logic [BYTE_W-1:0] tx_data = 8'h00;
    logic [BYTE_W-1:0] rx_data, got;
    logic [BYTE_W-1:0] last_rx = 8'h00;
    logic              scl_i, sda_i, sda_o, sda_oe, sda_pull, ack;
    logic              rx_valid, start_evt, stop_evt, nack_evt, standby, bus_idle;
    int                miscompares = 0;
    int                cmp_count = 0;
    int                n_start = 0, n_stop = 0, n_nack = 0;
    initial begin
        forever #5 clock = !clock;
    end
    initial begin
        #37;
        forever #80 link_clk = !link_clk;
    end
    assign sda_i = !(sda_pull || (sda_oe && !sda_o));
    ewl_link dut_u (
        .clock, .srst, .link_clk, .scl_i, .sda_i, .sda_o, .sda_oe,
        .power_on_release, .write_busy, .write_pending, .ack_en, .tx_mode,
        .tx_data, .rx_data, .rx_valid, .start_evt, .stop_evt, .nack_evt,
        .standby, .bus_idle
    );
    ewl_master partner_u (.scl(scl_i), .sda_pull(sda_pull), .sda(sda_i));
    always @(posedge clock) begin
        if (start_evt === 1'b1)
            n_start++;
        if (stop_evt === 1'b1)
            n_stop++;
        if (nack_evt === 1'b1)
            n_nack++;
        if (rx_valid === 1'b1)
            last_rx = rx_data;
    end
    // ********
    // Helpers and scenarios
    // ********
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_sb();
        int k;
        k = 0;
        while (standby !== 1'b1 && k < 20000) begin
            @(posedge clock);
            k++;
        end
        chk(standby, 1'b1);
        if (k >= 20000)
            complete_run();
    endtask
    task automatic t_power_on();
        partner_u.start_c();
        partner_u.xfer(8'hA5, 1'b1, got, ack);
        chk(ack, 1'b1);
        chk(n_start, 0);
        chk(standby, 1'b0);
        partner_u.stop_c();
        tick(1);
        power_on_release = 1'b1;
        wait_sb();
        tick(10000);
        partner_u.spike();
        tick(100);
        chk(n_start, 0);
    endtask
    task automatic t_rx_tx();
        partner_u.start_c();
        chk(n_start, 1);
        chk(standby, 1'b0);
        partner_u.xfer(8'hA5, 1'b1, got, ack);
        chk(ack, 1'b0);
        chk(last_rx, 8'hA5);
        tick(1);
        fork
            partner_u.xfer(8'h3C, 1'b1, got, ack);
            begin
                tick(200);
                tx_mode = 1'b1;
                tx_data = 8'h96;
            end
        join
        chk(ack, 1'b0);
        chk(last_rx, 8'h3C);
        fork
            partner_u.xfer(8'hFF, 1'b0, got, ack);
            begin
                tick(200);
                tx_data = 8'h5A;
            end
        join
        chk(got, 8'h96);
        partner_u.xfer(8'hFF, 1'b1, got, ack);
        chk(got, 8'h5A);
        chk(n_nack, 1);
        chk(sda_i, 1'b1);
        partner_u.stop_c();
        chk(n_stop, 1);
        chk(standby, 1'b1);
    endtask
    task automatic t_rep_write();
        tick(1);
        tx_mode = 1'b0;
        partner_u.start_c();
        partner_u.xfer(8'hA0, 1'b1, got, ack);
        partner_u.start_c();
        partner_u.xfer(8'h81, 1'b1, got, ack);
        chk(n_start, 3);
        chk(ack, 1'b0);
        chk(last_rx, 8'h81);
        tick(1);
        write_pending = 1'b1;
        partner_u.stop_c();
        chk(standby, 1'b0);
        tick(1);
        write_busy = 1'b1;
        write_pending = 1'b0;
        tick(100);
        partner_u.start_c();
        partner_u.xfer(8'h55, 1'b1, got, ack);
        chk(ack, 1'b1);
        partner_u.stop_c();
        chk(n_start, 3);
        chk(n_stop, 2);
        tick(1);
        write_busy = 1'b0;
        wait_sb();
    endtask
    task automatic t_recover();
        int k;
        logic seen;
        tick(1);
        tx_mode = 1'b1;
        tx_data = 8'h00;
        partner_u.start_c();
        partner_u.xfer(8'hA1, 1'b1, got, ack);
        repeat (3) partner_u.bit_x(1'b1, seen);
        k = 0;
        seen = 1'b0;
        while (seen !== 1'b1 && k < 9) begin
            partner_u.bit_x(1'b1, seen);
            k++;
        end
        chk(seen, 1'b1);
        partner_u.start_c();
        partner_u.stop_c();
        chk(n_stop, 3);
        chk(standby, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        repeat (3) @(posedge link_clk);
        tick(1);
        srst = 1'b0;
        tick(20);
        t_power_on();
        t_rx_tx();
        t_rep_write();
        t_recover();
        complete_run();
    end
endmodule // eeprom_two_wire_slave_link_bench
